// ===== zcd_defs.svh
/*
 * Register offsets, field positions and reset values of the zero-cross detector registers.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ZCD_DEFS_SVH
`define ZCD_DEFS_SVH

`define ZCD_ADDR_W           2
`define ZCD_OFF_CONTROL      2'h0
`define ZCD_OFF_RESERVED     2'h1
`define ZCD_OFF_EDGE_CTRL    2'h2
`define ZCD_OFF_STATUS       2'h3

`define ZCD_BIT_ENABLE       0
`define ZCD_BIT_INVERT       3
`define ZCD_BIT_PIN_OE       6
`define ZCD_BIT_STANDBY_RUN  7
`define ZCD_BIT_CROSS_FLAG   0
`define ZCD_BIT_STATE        4

`define ZCD_RST_CONTROL      8'h00
`define ZCD_RST_EDGE_CTRL    8'h00
`define ZCD_SYNC_STAGES      3

`endif

// ===== zcd_pkg.sv
/*
 * Types shared by the zero-cross detector register bank.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none

package zcd_pkg;

	typedef enum logic [1:0] {
		ZCD_EDGE_NONE,
		ZCD_EDGE_RISING,
		ZCD_EDGE_FALLING,
		ZCD_EDGE_BOTH
	} zcd_edge_mode_t;

	typedef struct packed {
		logic standby_run;
		logic pin_output_enable;
		logic invert;
		logic enable;
	} zcd_control_t;

	typedef enum logic [1:0] {
		ZCD_PWR_ACTIVE,
		ZCD_PWR_IDLE,
		ZCD_PWR_STANDBY,
		ZCD_PWR_DOWN
	} zcd_sleep_t;

endpackage : zcd_pkg

`default_nettype wire

// ===== zcd_sync.sv
/*
 * Multi-stage level synchronizer for the comparator output.
 * Assumes the input is a slowly changing asynchronous level.
 */
`default_nettype none

module zcd_sync #(
	parameter int STAGES = 3
) (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic d_i,
	output var  logic q_o
);

	logic [STAGES-1:0] chain_q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chain_q <= '0;
		end else begin
			chain_q <= {chain_q[STAGES-2:0], d_i};
		end
	end

	assign q_o = chain_q[STAGES-1];

endmodule : zcd_sync

`default_nettype wire

// ===== zcd_regs.sv
/*
 * Register bank, output path and cross flag of the zero-cross detector.
 * Assumes a one-cycle strobe bus master and a comparator output level input.
 */
`include "zcd_defs.svh"
`default_nettype none

module zcd_regs (
	input  wire logic                   clk_i,
	input  wire logic                   arst_n_i,
	input  wire logic [`ZCD_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]             wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output var  logic [7:0]             rdata_o,
	input  wire logic                   comp_out_i,
	input  wire zcd_pkg::zcd_sleep_t    sleep_i,
	output var  logic                   pin_out_o,
	output var  logic                   pin_oe_n_o,
	output var  logic                   event_out_o,
	output var  logic                   irq_o
);

	////////////////////////////////////////////////////////////////////////////
	zcd_pkg::zcd_control_t    ctrl_q;
	zcd_pkg::zcd_edge_mode_t  mode_q;
	logic                     flag_q;
	logic                     sync_raw;
	logic                     prev_q;
	logic                     active;
	logic                     out_now;
	logic                     rise;
	logic                     fall;
	logic                     edge_hit;
	logic                     clr_wr;
	logic                     flag_d;
	zcd_pkg::zcd_edge_mode_t  mode_d;

	// Reset images of the writable registers
	localparam logic [7:0] CTRL_RST = `ZCD_RST_CONTROL;
	localparam logic [7:0] EDGE_RST = `ZCD_RST_EDGE_CTRL;

	function automatic logic reg_hit(input logic [`ZCD_ADDR_W-1:0] a,
	                                  input logic [`ZCD_ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q.enable            <= CTRL_RST[`ZCD_BIT_ENABLE];
			ctrl_q.invert            <= CTRL_RST[`ZCD_BIT_INVERT];
			ctrl_q.pin_output_enable <= CTRL_RST[`ZCD_BIT_PIN_OE];
			ctrl_q.standby_run       <= CTRL_RST[`ZCD_BIT_STANDBY_RUN];
		end else if (wr_i && reg_hit(addr_i, `ZCD_OFF_CONTROL)) begin
			ctrl_q.enable            <= wdata_i[`ZCD_BIT_ENABLE];
			ctrl_q.invert            <= wdata_i[`ZCD_BIT_INVERT];
			ctrl_q.pin_output_enable <= wdata_i[`ZCD_BIT_PIN_OE];
			ctrl_q.standby_run       <= wdata_i[`ZCD_BIT_STANDBY_RUN];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_q <= zcd_pkg::zcd_edge_mode_t'(EDGE_RST[1:0]);
		end else if (wr_i && reg_hit(addr_i, `ZCD_OFF_EDGE_CTRL)) begin
			mode_q <= zcd_pkg::zcd_edge_mode_t'(wdata_i[1:0]);
		end
	end

	// Mode as it will stand after this edge
	assign mode_d = (wr_i && reg_hit(addr_i, `ZCD_OFF_EDGE_CTRL)) ?
		zcd_pkg::zcd_edge_mode_t'(wdata_i[1:0]) : mode_q;

	////////////////////////////////////////////////////////////////////////////
	// Activity from enable and sleep mode
	always_comb begin
		case (sleep_i)
			zcd_pkg::ZCD_PWR_ACTIVE:  active = ctrl_q.enable;
			zcd_pkg::ZCD_PWR_IDLE:    active = ctrl_q.enable;
			zcd_pkg::ZCD_PWR_STANDBY: active = ctrl_q.enable && ctrl_q.standby_run;
			zcd_pkg::ZCD_PWR_DOWN:    active = 1'b0;
			default:                  active = 1'b0;
		endcase
	end

	standby_stop_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(sleep_i == zcd_pkg::ZCD_PWR_STANDBY && !ctrl_q.standby_run) |-> !out_now)
		else $error("running in standby");
	standby_alive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(sleep_i == zcd_pkg::ZCD_PWR_STANDBY && ctrl_q.enable && ctrl_q.standby_run)
		|-> out_now == (sync_raw ^ ctrl_q.invert)) else $error("stopped in standby");

	zcd_sync #(
		.STAGES (`ZCD_SYNC_STAGES)
	) u_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      (comp_out_i),
		.q_o      (sync_raw)
	);

	assign out_now = active & (sync_raw ^ ctrl_q.invert);

	sync_delay_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(sleep_i == zcd_pkg::ZCD_PWR_ACTIVE && ctrl_q.enable && !ctrl_q.invert)[*4]
		|-> out_now == $past(comp_out_i, 3)) else $error("state delay wrong");

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= out_now;
		end
	end

	once_only_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		edge_hit |=> prev_q == $past(out_now)) else $error("edge repeated");

	assign rise = out_now & ~prev_q;
	assign fall = ~out_now & prev_q;

	always_comb begin
		case (mode_q)
			zcd_pkg::ZCD_EDGE_NONE:    edge_hit = 1'b0;
			zcd_pkg::ZCD_EDGE_RISING:  edge_hit = rise;
			zcd_pkg::ZCD_EDGE_FALLING: edge_hit = fall;
			zcd_pkg::ZCD_EDGE_BOTH:    edge_hit = rise | fall;
			default:                   edge_hit = 1'b0;
		endcase
	end

	no_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(mode_q == zcd_pkg::ZCD_EDGE_NONE && !flag_q) |=> !flag_q)
		else $error("flag set with mode none");

	////////////////////////////////////////////////////////////////////////////
	// Cross flag, set wins over clear
	assign clr_wr = wr_i && reg_hit(addr_i, `ZCD_OFF_STATUS) && wdata_i[`ZCD_BIT_CROSS_FLAG];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_q <= 1'b0;
		end else if (edge_hit) begin
			flag_q <= 1'b1;
		end else if (clr_wr) begin
			flag_q <= 1'b0;
		end
	end

	// Next flag value, so the request follows the flag without a lag
	assign flag_d = edge_hit | (flag_q & ~clr_wr);

	flag_sets_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		edge_hit |=> flag_q) else $error("cross flag not set by edge");
	zero_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(flag_q && !edge_hit && wr_i && reg_hit(addr_i, `ZCD_OFF_STATUS)
		&& !wdata_i[`ZCD_BIT_CROSS_FLAG]) |=> flag_q) else $error("zero write changed flag");
	one_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(clr_wr && !edge_hit) |=> !flag_q) else $error("one write did not clear");

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o       <= 1'b0;
			pin_out_o   <= 1'b0;
			pin_oe_n_o  <= 1'b1;
			event_out_o <= 1'b0;
		end else begin
			irq_o       <= (mode_d != zcd_pkg::ZCD_EDGE_NONE) && flag_d;
			pin_out_o   <= out_now;
			pin_oe_n_o  <= !(active && ctrl_q.pin_output_enable);
			event_out_o <= out_now;
		end
	end

	irq_follow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		irq_o == ((mode_q != zcd_pkg::ZCD_EDGE_NONE) && flag_q)) else $error("irq mismatch");
	disabled_quiet_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(!ctrl_q.enable) |=> !pin_out_o && pin_oe_n_o) else $error("off but driving");
	powerdown_off_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(sleep_i == zcd_pkg::ZCD_PWR_DOWN) |=> pin_oe_n_o && !pin_out_o)
		else $error("pin on in power-down");
	pin_enable_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(active && ctrl_q.pin_output_enable) |=> !pin_oe_n_o) else $error("pin not driven");
	pin_follow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		1'b1 |=> pin_out_o == $past(out_now) && event_out_o == $past(out_now))
		else $error("pin or event path wrong");

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`ZCD_OFF_CONTROL:   rdata_o <= {ctrl_q.standby_run, ctrl_q.pin_output_enable,
				                                2'b00, ctrl_q.invert, 2'b00, ctrl_q.enable};
				`ZCD_OFF_RESERVED:  rdata_o <= 8'h00;
				`ZCD_OFF_EDGE_CTRL: rdata_o <= {6'h00, mode_q};
				`ZCD_OFF_STATUS:    rdata_o <= {3'h0, out_now, 3'h0, flag_q};
				default:            rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	status_read_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(rd_i && reg_hit(addr_i, `ZCD_OFF_STATUS))
		|=> rdata_o == {3'h0, $past(out_now), 3'h0, $past(flag_q)}) else $error("status read wrong");

endmodule : zcd_regs

`default_nettype wire

// ===== zcd_front_model.sv
/*
 * Behavioural comparator front end: its output follows the requested input level.
 * Assumes the bench moves level_i just after a clock edge; the delay sets prompt or slow answers.
 */
`default_nettype none

module zcd_front_model #(
	parameter int DELAY_NS = 3
) (
	input  wire logic level_i,
	output var  logic comp_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// The comparator is push-pull, so its output is never released
	initial comp_o = 1'b0;
	always @(level_i) comp_o <= #(DELAY_NS) level_i;
endmodule : zcd_front_model

`default_nettype wire

// ===== zcd_regs_bench.sv
/*
 * Self-checking bench for the zero-cross detector register bank.
 * Assumes zcd_pkg, zcd_regs and zcd_front_model are compiled first.
 */
`default_nettype none

module zcd_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                clk_i, arst_n_i, wr_i, rd_i, lvl, comp;
	logic [1:0]          addr_i;
	logic [7:0]          wdata_i, rdata_o, d;
	logic                pin_out_o, pin_oe_n_o, event_out_o, irq_o;
	zcd_pkg::zcd_sleep_t sleep_i;
	int                  fail_count, cmp_count;

	zcd_front_model #(.DELAY_NS(3)) fe (.level_i(lvl), .comp_o(comp));

	zcd_regs dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comp_out_i(comp), .sleep_i(sleep_i),
		.pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .event_out_o(event_out_o),
		.irq_o(irq_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o;
	endtask : rd

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// Moves the comparator level, then waits well past the synchronizer
	task automatic settle(input logic v);
		@(posedge clk_i);
		lvl <= v;
		repeat (8) @(posedge clk_i);
		#1;
	endtask : settle

	task automatic pins(input logic [2:0] e);
		chk({5'h00, pin_out_o, pin_oe_n_o, event_out_o}, {5'h00, e});
	endtask : pins

	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		fail_count++;
		close_out();
	end

	initial begin
		{wr_i, rd_i, lvl} = 3'h0;
		addr_i     = 2'h0;
		wdata_i    = 8'h00;
		sleep_i    = zcd_pkg::ZCD_PWR_ACTIVE;
		arst_n_i   = 1'b0;
		fail_count = 0;
		cmp_count  = 0;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		for (int a = 0; a < 4; a++) begin
			rd(a[1:0], d);
			chk(d, 8'h00);
		end
		wr(2'h1, 8'hFF);
		wr(2'h0, 8'hFF);
		rd(2'h1, d);
		chk(d, 8'h00);
		rd(2'h0, d);
		chk(d, 8'hC9);
		wr(2'h2, 8'hFF);
		rd(2'h2, d);
		chk(d, 8'h03);
		wr(2'h0, 8'h01);
		settle(1'b0);
		for (int m = 0; m < 4; m++) begin
			wr(2'h2, 8'(m));
			wr(2'h3, 8'h01);
			settle(1'b1);
			rd(2'h3, d);
			chk(d, {7'h08, m[0]});
			chk({7'h00, irq_o}, {7'h00, m[0]});
			settle(1'b0);
			rd(2'h3, d);
			chk(d, {7'h00, m != 0});
			wr(2'h3, 8'h00);
			rd(2'h3, d);
			chk(d, {7'h00, m != 0});
			chk({7'h00, irq_o}, {7'h00, m != 0});
			wr(2'h3, 8'h01);
			rd(2'h3, d);
			chk(d, 8'h00);
			chk({7'h00, irq_o}, 8'h00);
		end
		wr(2'h0, 8'h49);
		settle(1'b0);
		rd(2'h3, d);
		chk(d, 8'h11);
		pins(3'b101);
		wr(2'h2, 8'h00);
		rd(2'h3, d);
		chk({6'h00, d[0], irq_o}, 8'h02);
		wr(2'h2, 8'h03);
		rd(2'h3, d);
		chk({6'h00, d[0], irq_o}, 8'h03);
		@(posedge clk_i);
		sleep_i <= zcd_pkg::ZCD_PWR_STANDBY;
		settle(1'b0);
		pins(3'b010);
		wr(2'h0, 8'hC9);
		settle(1'b0);
		pins(3'b101);
		@(posedge clk_i);
		sleep_i <= zcd_pkg::ZCD_PWR_DOWN;
		settle(1'b0);
		pins(3'b010);
		@(posedge clk_i);
		sleep_i <= zcd_pkg::ZCD_PWR_IDLE;
		wr(2'h0, 8'h48);
		settle(1'b1);
		rd(2'h3, d);
		chk(d & 8'h10, 8'h00);
		pins(3'b010);
		close_out();
	end
endmodule : zcd_regs_bench

`default_nettype wire
